//--- logic/line_cfg_pkg.sv
// Package: register map, field layouts, reset values and timing of the line configuration bank
`default_nettype none
package line_cfg_pkg;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam int unsigned IDX_W           = 10;
  localparam logic [9:0]  IDX_PULSE_SHAPE = 10'h023;
  localparam logic [9:0]  IDX_AMP_SCALE   = 10'h024;
  localparam logic [9:0]  IDX_TPL_CTRL    = 10'h025;
  localparam logic [9:0]  IDX_TPL_DATA    = 10'h026;
  localparam logic [9:0]  IDX_RJA_CFG     = 10'h027;
  localparam logic [9:0]  IDX_RX_PATH     = 10'h028;
  localparam logic [9:0]  IDX_RX_EQ_LOS   = 10'h029;
  localparam logic [9:0]  IDX_RX_SLICER_THRESHOLD    = 10'h02a;
  localparam logic [9:0]  IDX_RX_STATUS   = 10'h039;

  // ****************************************
  // Field layouts (bit 0 is the last member)
  // ****************************************
  typedef struct packed {
    logic       access_enable;
    logic       access_read;
    logic [1:0] unit_interval;
    logic [3:0] template_sample_index;
  } tpl_ctrl_t;

  typedef struct packed {
    logic       rx_pointer_monitor_mode;
    logic       rx_widen_limit;
    logic       rx_attenuator_enable;
    logic [1:0] rx_attenuator_depth;
    logic       rx_attenuator_corner;
  } rja_cfg_t;

  typedef struct packed {
    logic       rx_power_off;
    logic [2:0] reserved;
    logic       rx_line_code_select;
  } rx_path_t;

  typedef struct packed {
    logic       equalizer_on;
    logic       reserved;
    logic [4:0] los_threshold_code;
  } rx_eq_los_t;

  typedef struct packed {
    logic [1:0] slicer_threshold;
    logic [1:0] peak_update_window;
    logic [1:0] monitor_gain;
  } rx_slicer_threshold_t;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] RST_PULSE_SHAPE = 4'h0;
  localparam logic [5:0] RST_AMP_SCALE   = 6'h21;
  localparam logic [7:0] RST_TPL_CTRL    = 8'h00;
  localparam logic [6:0] RST_TPL_DATA    = 7'h00;
  localparam logic [5:0] RST_RJA_CFG     = 6'h00;
  localparam logic [4:0] RST_RX_PATH     = 5'h00;
  localparam logic [6:0] RST_RX_EQ_LOS   = 7'h15;
  localparam logic [5:0] RST_RX_SLICER_THRESHOLD    = 6'h18;

  // ****************************************
  // Codes and counts
  // ****************************************
  localparam logic [1:0] ARB_WAVE_TOP    = 2'h3;
  localparam logic [7:0] DEPTH_128       = 8'h80;
  localparam logic [7:0] DEPTH_64        = 8'h40;
  localparam logic [7:0] DEPTH_32        = 8'h20;
  localparam logic [7:0] MARGIN_128      = 8'h04;
  localparam logic [7:0] MARGIN_64       = 8'h03;
  localparam logic [7:0] MARGIN_32       = 8'h02;
  localparam logic [5:0] LOS_Q_BASE_DB   = 6'h04;
  localparam logic [5:0] LOS_Q_MAX_DB    = 6'h30;
  localparam logic [4:0] LOS_CODE_MAX    = 5'h16;
  localparam int unsigned LOS_RUN_BITS   = 175;
  localparam logic [7:0] OBS_BASE_BITS   = 8'h20;

endpackage
`default_nettype wire

//--- logic/line_cfg_bank.sv
// Per-link line interface configuration bank with Wishbone register slave
// Operation
// - Amplitude scale applies only to arbitrary waveform
// - Template access honoured only in arbitrary mode
// - Template RAM access only when enable is set
// - Direction bit zero writes, one reads
// - Address RAM by unit interval and sample
// - Write stores seven-bit sample into RAM
// - Pointer monitor shows live or peak interval
// - Widen bandwidth near FIFO over or underflow
// - Enable bit switches receive attenuator on
// - Depth code selects 128, 64 or 32
// - Corner bit selects 5 Hz or 1.26 Hz
// - Power-off bit powers receive path down
// - Line code bit selects B8ZS or AMI
// - Equalizer bit selects short or long haul
// - Threshold code maps to Q in long haul
// - Declare loss after quiet run below Q
// - Top bits 11 select arbitrary waveform
// - Peak observation period 32 to 256 bits
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module line_cfg_bank #(
  parameter int unsigned ADDR_W   = 12,
  parameter int unsigned LOS_RUN  = line_cfg_pkg::LOS_RUN_BITS,
  parameter int unsigned TPL_UI   = 4,
  parameter int unsigned TPL_TEMPLATE_SAMPLE_INDEX = 16
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  input  wire logic              we_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  output logic                   ack_o,
  // Transmit pulse generator
  input  wire logic [5:0]        tpl_rd_addr_i,
  output logic      [6:0]        tpl_sample_o,
  output logic      [3:0]        pulse_shape_select_o,
  output logic                   arb_wave_o,
  output logic      [5:0]        amplitude_step_code_o,
  // Receive jitter attenuator
  input  wire logic [6:0]        ptr_interval_i,
  output logic                   rja_enable_o,
  output logic      [7:0]        rja_depth_o,
  output logic                   rja_corner_o,
  output logic                   rja_widen_o,
  // Receive path control
  output logic                   rx_power_down_o,
  output logic                   rx_ami_o,
  output logic                   equalizer_on_o,
  output logic      [5:0]        los_q_db_o,
  output logic      [1:0]        slicer_threshold_o,
  output logic      [1:0]        monitor_gain_o,
  // Line monitor pins
  input  wire logic              rx_bit_clk_i,
  input  wire logic              rx_below_q_i,
  input  wire logic              rx_transition_i,
  output logic                   los_o,
  output logic                   peak_window_o
);

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic                          req;
  wire logic                          wr;
  wire logic [line_cfg_pkg::IDX_W-1:0] idx;
  wire logic                          wr_lane;
  assign req     = cyc_i & stb_i & ~ack_o;
  assign wr      = req & we_i;
  assign idx     = adr_i[ADDR_W-1:2];
  assign wr_lane = wr & sel_i[0];

  wire logic wr_shape;
  wire logic wr_amp;
  wire logic wr_tctl;
  wire logic wr_tdat;
  wire logic wr_rja;
  wire logic wr_rxp;
  wire logic wr_eq;
  wire logic wr_slc;
  assign wr_shape = wr_lane & (idx == line_cfg_pkg::IDX_PULSE_SHAPE);
  assign wr_amp   = wr_lane & (idx == line_cfg_pkg::IDX_AMP_SCALE);
  assign wr_tctl  = wr_lane & (idx == line_cfg_pkg::IDX_TPL_CTRL);
  assign wr_tdat  = wr_lane & (idx == line_cfg_pkg::IDX_TPL_DATA);
  assign wr_rja   = wr_lane & (idx == line_cfg_pkg::IDX_RJA_CFG);
  assign wr_rxp   = wr_lane & (idx == line_cfg_pkg::IDX_RX_PATH);
  assign wr_eq    = wr_lane & (idx == line_cfg_pkg::IDX_RX_EQ_LOS);
  assign wr_slc   = wr_lane & (idx == line_cfg_pkg::IDX_RX_SLICER_THRESHOLD);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic      [3:0]              pulse_shape;
  logic      [5:0]              amp_scale;
  line_cfg_pkg::tpl_ctrl_t      tpl_ctrl;
  logic      [6:0]              tpl_data;
  line_cfg_pkg::rja_cfg_t       rja_cfg;
  line_cfg_pkg::rx_path_t       rx_path;
  line_cfg_pkg::rx_eq_los_t     rx_eq;
  line_cfg_pkg::rx_slicer_threshold_t      rx_slc;
  logic      [6:0]              ptr_int;
  logic                         los;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_shape <= line_cfg_pkg::RST_PULSE_SHAPE;
      amp_scale   <= line_cfg_pkg::RST_AMP_SCALE;
      rja_cfg     <= line_cfg_pkg::RST_RJA_CFG;
      rx_path     <= line_cfg_pkg::RST_RX_PATH;
      rx_eq       <= line_cfg_pkg::RST_RX_EQ_LOS;
      rx_slc      <= line_cfg_pkg::RST_RX_SLICER_THRESHOLD;
    end else begin
      if (wr_shape) pulse_shape <= dat_i[3:0];
      if (wr_amp)   amp_scale   <= dat_i[5:0];
      if (wr_rja)   rja_cfg     <= dat_i[5:0];
      if (wr_rxp)   rx_path     <= {dat_i[4], 3'h0, dat_i[0]};
      if (wr_eq)    rx_eq       <= {dat_i[6], 1'b0, dat_i[4:0]};
      if (wr_slc)   rx_slc      <= dat_i[5:0];
    end
  end

  // ****************************************
  // Pulse template access
  // ****************************************
  logic [6:0] tpl_ram [TPL_UI*TPL_TEMPLATE_SAMPLE_INDEX];
  wire logic       arb_mode;
  wire logic       tpl_go;
  wire logic [5:0] tpl_addr;
  assign arb_mode = (pulse_shape[3:2] == line_cfg_pkg::ARB_WAVE_TOP);
  assign tpl_go   = tpl_ctrl.access_enable & arb_mode;
  assign tpl_addr = {tpl_ctrl.unit_interval, tpl_ctrl.template_sample_index};

  // Enable bit self-clears once the access is done; a new write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tpl_ctrl <= line_cfg_pkg::RST_TPL_CTRL;
    end else if (wr_tctl) begin
      tpl_ctrl <= dat_i[7:0];
    end else if (tpl_go) begin
      tpl_ctrl.access_enable <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (tpl_go && !tpl_ctrl.access_read) begin
      tpl_ram[tpl_addr] <= tpl_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tpl_data <= line_cfg_pkg::RST_TPL_DATA;
    end else if (tpl_go && tpl_ctrl.access_read) begin
      tpl_data <= tpl_ram[tpl_addr];
    end else if (wr_tdat) begin
      tpl_data <= dat_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tpl_sample_o <= 7'h00;
    end else begin
      tpl_sample_o <= tpl_ram[tpl_rd_addr_i];
    end
  end

  // ****************************************
  // Transmit outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_shape_select_o  <= line_cfg_pkg::RST_PULSE_SHAPE;
      arb_wave_o            <= 1'b0;
      amplitude_step_code_o <= 6'h00;
    end else begin
      pulse_shape_select_o  <= pulse_shape;
      arb_wave_o            <= arb_mode;
      amplitude_step_code_o <= arb_mode ? amp_scale : 6'h00;
    end
  end

  // ****************************************
  // Receive jitter attenuator
  // ****************************************
  wire logic [7:0] depth;
  wire logic [7:0] margin;
  wire logic [7:0] fill;
  wire logic       near_edge;
  assign depth  = (rja_cfg.rx_attenuator_depth == 2'h0) ? line_cfg_pkg::DEPTH_128 :
                  (rja_cfg.rx_attenuator_depth == 2'h1) ? line_cfg_pkg::DEPTH_64 :
                  line_cfg_pkg::DEPTH_32;
  assign margin = (rja_cfg.rx_attenuator_depth == 2'h0) ? line_cfg_pkg::MARGIN_128 :
                  (rja_cfg.rx_attenuator_depth == 2'h1) ? line_cfg_pkg::MARGIN_64 :
                  line_cfg_pkg::MARGIN_32;
  assign fill      = {1'b0, ptr_interval_i};
  assign near_edge = (fill <= margin) | (fill >= depth - margin);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rja_enable_o <= 1'b0;
      rja_depth_o  <= line_cfg_pkg::DEPTH_128;
      rja_corner_o <= 1'b0;
      rja_widen_o  <= 1'b0;
    end else begin
      rja_enable_o <= rja_cfg.rx_attenuator_enable;
      rja_depth_o  <= depth;
      rja_corner_o <= rja_cfg.rx_attenuator_corner;
      rja_widen_o  <= rja_cfg.rx_attenuator_enable & rja_cfg.rx_widen_limit & near_edge;
    end
  end

  // Live interval, or largest seen while in peak mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_int <= 7'h00;
    end else if (!rja_cfg.rx_pointer_monitor_mode) begin
      ptr_int <= ptr_interval_i;
    end else if (ptr_interval_i > ptr_int) begin
      ptr_int <= ptr_interval_i;
    end
  end

  // ****************************************
  // Receive path outputs
  // ****************************************
  wire logic [5:0] q_db;
  assign q_db = (rx_eq.los_threshold_code >= line_cfg_pkg::LOS_CODE_MAX) ? line_cfg_pkg::LOS_Q_MAX_DB :
                line_cfg_pkg::LOS_Q_BASE_DB + {rx_eq.los_threshold_code, 1'b0};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_power_down_o    <= 1'b0;
      rx_ami_o           <= 1'b0;
      equalizer_on_o     <= 1'b0;
      los_q_db_o         <= 6'h00;
      slicer_threshold_o <= 2'h0;
      monitor_gain_o     <= 2'h0;
    end else begin
      rx_power_down_o    <= rx_path.rx_power_off;
      rx_ami_o           <= rx_path.rx_line_code_select;
      equalizer_on_o     <= rx_eq.equalizer_on;
      los_q_db_o         <= rx_eq.equalizer_on ? q_db : 6'h00;
      slicer_threshold_o <= rx_slc.slicer_threshold;
      monitor_gain_o     <= rx_slc.monitor_gain;
    end
  end

  // ****************************************
  // Line monitor pin synchronisers
  // ****************************************
  logic [1:0] bclk_s;
  logic [1:0] below_s;
  logic [1:0] trans_s;
  logic       bclk_d;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bclk_s  <= 2'h0;
      below_s <= 2'h0;
      trans_s <= 2'h0;
      bclk_d  <= 1'b0;
    end else begin
      bclk_s  <= {bclk_s[0], rx_bit_clk_i};
      below_s <= {below_s[0], rx_below_q_i};
      trans_s <= {trans_s[0], rx_transition_i};
      bclk_d  <= bclk_s[1];
    end
  end

  wire logic bit_tick;
  wire logic quiet;
  assign bit_tick = bclk_s[1] & ~bclk_d;
  assign quiet    = below_s[1] & ~trans_s[1];

  // ****************************************
  // Loss of signal
  // ****************************************
  logic [$clog2(LOS_RUN+1)-1:0] los_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      los_cnt <= '0;
      los     <= 1'b0;
    end else if (bit_tick) begin
      if (!quiet) begin
        los_cnt <= '0;
        los     <= 1'b0;
      end else if (los_cnt == ($clog2(LOS_RUN+1))'(LOS_RUN - 1)) begin
        los     <= 1'b1;
      end else begin
        los_cnt <= los_cnt + 1'b1;
      end
    end
  end

  // ****************************************
  // Peak observation window
  // ****************************************
  logic [7:0] obs_cnt;
  wire logic [8:0] obs_len;
  wire logic [7:0] obs_last;
  assign obs_len  = {1'b0, line_cfg_pkg::OBS_BASE_BITS} << rx_slc.peak_update_window;
  assign obs_last = 8'(obs_len - 9'h001);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      obs_cnt       <= 8'h00;
      peak_window_o <= 1'b0;
      los_o         <= 1'b0;
    end else begin
      los_o         <= los;
      peak_window_o <= bit_tick & (obs_cnt >= obs_last);
      if (bit_tick) begin
        obs_cnt <= (obs_cnt >= obs_last) ? 8'h00 : obs_cnt + 8'h01;
      end
    end
  end

  // ****************************************
  // Read mux and acknowledge
  // ****************************************
  // One-hot register select
  wire logic       rd_shape;
  wire logic       rd_amp;
  wire logic       rd_tctl;
  wire logic       rd_tdat;
  wire logic       rd_rja;
  wire logic       rd_rxp;
  wire logic       rd_eq;
  wire logic       rd_slc;
  wire logic       rd_stat;
  wire logic [7:0] rd_byte;

  assign rd_shape = (idx == line_cfg_pkg::IDX_PULSE_SHAPE);
  assign rd_amp   = (idx == line_cfg_pkg::IDX_AMP_SCALE);
  assign rd_tctl  = (idx == line_cfg_pkg::IDX_TPL_CTRL);
  assign rd_tdat  = (idx == line_cfg_pkg::IDX_TPL_DATA);
  assign rd_rja   = (idx == line_cfg_pkg::IDX_RJA_CFG);
  assign rd_rxp   = (idx == line_cfg_pkg::IDX_RX_PATH);
  assign rd_eq    = (idx == line_cfg_pkg::IDX_RX_EQ_LOS);
  assign rd_slc   = (idx == line_cfg_pkg::IDX_RX_SLICER_THRESHOLD);
  assign rd_stat  = (idx == line_cfg_pkg::IDX_RX_STATUS);

  assign rd_byte = ({8{rd_shape}} & {4'h0, pulse_shape}) |
                   ({8{rd_amp}}   & {2'h0, amp_scale}) |
                   ({8{rd_tctl}}  & tpl_ctrl) |
                   ({8{rd_tdat}}  & {1'b0, tpl_data}) |
                   ({8{rd_rja}}   & {2'h0, rja_cfg}) |
                   ({8{rd_rxp}}   & {3'h0, rx_path}) |
                   ({8{rd_eq}}    & {1'b0, rx_eq}) |
                   ({8{rd_slc}}   & {2'h0, rx_slc}) |
                   ({8{rd_stat}}  & {los, ptr_int});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= (req && !we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule  // line_cfg_bank
`default_nettype wire

//--- sim/line_cfg_bank_sva.sv
// Assertion checker for the line configuration bank
`timescale 1ns/1ps
`default_nettype none
module line_cfg_bank_sva (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // Observed outputs
  input wire logic [3:0]  pulse_shape_select_o,
  input wire logic        arb_wave_o,
  input wire logic [5:0]  amplitude_step_code_o,
  input wire logic        rja_enable_o,
  input wire logic [7:0]  rja_depth_o,
  input wire logic        rja_widen_o,
  input wire logic        equalizer_on_o,
  input wire logic [5:0]  los_q_db_o,
  input wire logic        peak_window_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  AST_ACK_RESP: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  AST_RST_ACK: assert property ($fell(rst_i) |-> !ack_o) else $error("ack after reset");
  AST_DAT_IDLE: assert property (dat_o[31:8] == 24'h0 && (ack_o || dat_o[7:0] == 8'h00))
    else $error("read data outside ack");
  AST_ARB: assert property (arb_wave_o == (pulse_shape_select_o[3:2] == 2'h3))
    else $error("arbitrary flag wrong");
  AST_AMP: assert property (!arb_wave_o && !$past(arb_wave_o) |-> amplitude_step_code_o == 6'h00)
    else $error("scale applied to built-in shape");
  AST_DEPTH: assert property (rja_depth_o inside {8'h80, 8'h40, 8'h20})
    else $error("bad depth");
  AST_WIDEN: assert property (rja_widen_o |-> rja_enable_o || $past(rja_enable_o))
    else $error("widen while disabled");
  AST_LOSQ_OFF: assert property (!equalizer_on_o && !$past(equalizer_on_o) |-> los_q_db_o == 6'h00)
    else $error("threshold in short haul");
  AST_LOSQ_RANGE: assert property (equalizer_on_o && $past(equalizer_on_o) |->
    los_q_db_o >= 6'h04 && los_q_db_o <= 6'h30 && !los_q_db_o[0]) else $error("threshold out of range");
  AST_PEAK: assert property (peak_window_o |=> !peak_window_o)
    else $error("window pulse too long");
endmodule // line_cfg_bank_sva
bind line_cfg_bank line_cfg_bank_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dat_o,
  .pulse_shape_select_o, .arb_wave_o, .amplitude_step_code_o, .rja_enable_o, .rja_depth_o,
  .rja_widen_o, .equalizer_on_o, .los_q_db_o, .peak_window_o);
`default_nettype wire

//--- sim/tb_line_cfg_bank.sv
// Self-checking testbench for the line configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_line_cfg_bank;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [11:0] adr_i = 12'h000;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [5:0]  tpl_rd_addr_i = 6'h00;
  logic [6:0]  ptr_interval_i = 7'h00;
  logic        rx_bit_clk_i = 1'b0, rx_below_q_i = 1'b0, rx_transition_i = 1'b0;
  logic [31:0] dat_o;
  logic [6:0]  tpl_sample_o;
  logic [3:0]  pulse_shape_select_o;
  logic [5:0]  amplitude_step_code_o, los_q_db_o;
  logic [7:0]  rja_depth_o;
  logic [1:0]  slicer_threshold_o, monitor_gain_o;
  logic        ack_o, arb_wave_o, rja_enable_o, rja_corner_o, rja_widen_o, rx_power_down_o;
  logic        rx_ami_o, equalizer_on_o, los_o, peak_window_o;
  int          err_count = 0;
  int          total_checks = 0;
  int          pk = 0;

  line_cfg_bank #(.LOS_RUN(8)) dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .tpl_rd_addr_i, .tpl_sample_o, .pulse_shape_select_o, .arb_wave_o,
    .amplitude_step_code_o, .ptr_interval_i, .rja_enable_o, .rja_depth_o, .rja_corner_o,
    .rja_widen_o, .rx_power_down_o, .rx_ami_o, .equalizer_on_o, .los_q_db_o, .slicer_threshold_o,
    .monitor_gain_o, .rx_bit_clk_i, .rx_below_q_i, .rx_transition_i, .los_o, .peak_window_o);

  always #20 clk_i = ~clk_i;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [9:0] ix, input logic w, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'h1;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    if (ack_o !== 1'b1) begin
      err_count++;
      test_done();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [31:0] r;
    wb(ix, 1'b1, d, r);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic rdc(input logic [9:0] ix, input logic [7:0] e);
    logic [31:0] r;
    wb(ix, 1'b0, 8'h00, r);
    chk(r, {24'h0, e});
  endtask

  task automatic tick();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      rx_bit_clk_i <= (k < 4);
      if (peak_window_o === 1'b1) pk++;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] rv [8] = '{8'h00, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h15, 8'h18};
    for (int i = 0; i < 8; i++) rdc(10'h023 + 10'(i), rv[i]);
    chk(rja_depth_o, 8'h80);
    wr(10'h030, 8'hff);
    rdc(10'h030, 8'h00);
  endtask

  task automatic t_amp();
    logic [5:0] c [4] = '{6'h04, 6'h08, 6'h11, 6'h36};
    for (int i = 0; i < 4; i++) begin
      wr(10'h024, {2'b00, c[i]});
      wr(10'h023, {6'h02, 2'(i)});
      chk({pulse_shape_select_o, arb_wave_o, amplitude_step_code_o}, {2'b10, 2'(i), 7'h00});
      wr(10'h023, {6'h03, 2'(i)});
      chk({pulse_shape_select_o, arb_wave_o, amplitude_step_code_o}, {2'b11, 2'(i), 1'b1, c[i]});
      rdc(10'h024, {2'b00, c[i]});
    end
  endtask

  task automatic t_tpl();
    wr(10'h023, 8'h0c);
    for (int i = 0; i < 4; i++) begin
      wr(10'h026, 8'h40 | 8'(i * 9));
      wr(10'h025, {2'b10, 2'(i), 4'(15 - i)});
      rdc(10'h025, {2'b00, 2'(i), 4'(15 - i)});
    end
    for (int i = 0; i < 4; i++) begin
      tpl_rd_addr_i <= {2'(i), 4'(15 - i)};
      repeat (3) @(posedge clk_i);
      chk(tpl_sample_o, 7'h40 | 7'(i * 9));
    end
    wr(10'h023, 8'h02);
    wr(10'h026, 8'h7e);
    wr(10'h025, 8'h8f);
    rdc(10'h025, 8'h8f);
    tpl_rd_addr_i <= 6'h0f;
    wr(10'h023, 8'h0e);
    rdc(10'h025, 8'h0f);
    chk(tpl_sample_o, 7'h7e);
    wr(10'h026, 8'h33);
    wr(10'h025, 8'h0f);
    chk(tpl_sample_o, 7'h7e);
    wr(10'h026, 8'h00);
    wr(10'h025, 8'hde);
    rdc(10'h026, 8'h49);
  endtask

  task automatic t_rja();
    logic [7:0] dep [4] = '{8'h80, 8'h40, 8'h20, 8'h20};
    logic [7:0] mar [4] = '{8'h04, 8'h03, 8'h02, 8'h02};
    for (int i = 0; i < 4; i++) begin
      ptr_interval_i <= 7'(mar[i]);
      wr(10'h027, {5'h03, 2'(i), 1'(i)});
      chk({rja_enable_o, rja_corner_o, rja_depth_o}, {1'b1, 1'(i), dep[i]});
      chk(rja_widen_o, 1'b1);
      ptr_interval_i <= 7'(mar[i] + 8'h01);
      repeat (4) @(posedge clk_i);
      chk(rja_widen_o, 1'b0);
      ptr_interval_i <= 7'(dep[i] - mar[i]);
      repeat (4) @(posedge clk_i);
      chk(rja_widen_o, 1'b1);
    end
    wr(10'h027, 8'h10);
    chk({rja_enable_o, rja_widen_o}, 2'b00);
    ptr_interval_i <= 7'h2a;
    wr(10'h027, 8'h00);
    rdc(10'h039, 8'h2a);
    wr(10'h027, 8'h20);
    ptr_interval_i <= 7'h50;
    repeat (3) @(posedge clk_i);
    ptr_interval_i <= 7'h11;
    repeat (3) @(posedge clk_i);
    rdc(10'h039, 8'h50);
  endtask

  task automatic t_rx();
    logic [4:0] c [5] = '{5'h00, 5'h0a, 5'h15, 5'h16, 5'h1f};
    logic [5:0] q [5] = '{6'h04, 6'h18, 6'h2e, 6'h30, 6'h30};
    wr(10'h028, 8'h11);
    chk({rx_power_down_o, rx_ami_o}, 2'b11);
    wr(10'h028, 8'h00);
    chk({rx_power_down_o, rx_ami_o}, 2'b00);
    for (int i = 0; i < 5; i++) begin
      wr(10'h029, {3'b010, c[i]});
      chk({equalizer_on_o, los_q_db_o}, {1'b1, q[i]});
    end
    wr(10'h029, 8'h05);
    chk({equalizer_on_o, los_q_db_o}, 7'h00);
    wr(10'h02a, 8'h2d);
    chk({slicer_threshold_o, monitor_gain_o}, 4'h9);
  endtask

  task automatic t_los();
    rx_below_q_i <= 1'b1;
    repeat (7) tick();
    chk(los_o, 1'b0);
    tick();
    repeat (4) @(posedge clk_i);
    chk(los_o, 1'b1);
    rdc(10'h039, 8'hd0);
    rx_transition_i <= 1'b1;
    tick();
    repeat (4) @(posedge clk_i);
    chk(los_o, 1'b0);
    rx_transition_i <= 1'b0;
  endtask

  task automatic t_peak();
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(10'h02a, {4'h1, 2'(i), 2'b00});
      for (int r = 0; r < 2; r++) begin
        pk = 0;
        n = 0;
        while (pk == 0 && n < 600) begin
          tick();
          n++;
        end
        if (pk == 0) begin
          err_count++;
          test_done();
        end
      end
      chk(n, 32 << i);
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_amp();
    t_tpl();
    t_rja();
    t_rx();
    t_los();
    t_peak();
    test_done();
  end
endmodule // tb_line_cfg_bank
`default_nettype wire
